//--- hw/iad_defines.vh
// constants for the integer divide, shift and bit-field datapath
`ifndef IAD_DEFINES_VH
`define IAD_DEFINES_VH
`define IAD_OP_QPREP_W     6'h00
`define IAD_OP_QPREP_WU    6'h01
`define IAD_OP_QPREP_H     6'h02
`define IAD_OP_QPREP_HU    6'h03
`define IAD_OP_QPREP_B     6'h04
`define IAD_OP_QPREP_BU    6'h05
`define IAD_OP_QSTEP       6'h06
`define IAD_OP_QSTEP_U     6'h07
`define IAD_OP_FIXUP       6'h08
`define IAD_OP_MAG         6'h09
`define IAD_OP_MAG_S       6'h0a
`define IAD_OP_DMAG        6'h0b
`define IAD_OP_DMAG_S      6'h0c
`define IAD_OP_MIN         6'h0d
`define IAD_OP_MIN_U       6'h0e
`define IAD_OP_MAX         6'h0f
`define IAD_OP_MAX_U       6'h10
`define IAD_OP_CLAMP_B     6'h11
`define IAD_OP_CLAMP_BU    6'h12
`define IAD_OP_CLAMP_H     6'h13
`define IAD_OP_CLAMP_HU    6'h14
`define IAD_OP_GADD        6'h15
`define IAD_OP_GSUB        6'h16
`define IAD_OP_IGADD       6'h17
`define IAD_OP_IGSUB       6'h18
`define IAD_OP_SELECT      6'h19
`define IAD_OP_AND         6'h1a
`define IAD_OP_OR          6'h1b
`define IAD_OP_XOR         6'h1c
`define IAD_OP_NAND        6'h1d
`define IAD_OP_NOR         6'h1e
`define IAD_OP_XNOR        6'h1f
`define IAD_OP_ANDINV      6'h20
`define IAD_OP_ORINV       6'h21
`define IAD_OP_ZLEAD       6'h22
`define IAD_OP_OLEAD       6'h23
`define IAD_OP_SLEAD       6'h24
`define IAD_OP_ZFMOVE      6'h25
`define IAD_OP_SMOVE       6'h26
`define IAD_OP_CSMOVE      6'h27
`define IAD_OP_PULL_S      6'h28
`define IAD_OP_PULL_U      6'h29
`define IAD_OP_PAIRPULL    6'h2a
`define IAD_OP_INSERT      6'h2b
`define IAD_QSH_W          6'd0
`define IAD_QSH_H          6'd16
`define IAD_QSH_B          6'd24
`define IAD_STEP_BITS      8
`define IAD_BF_IMM         2'd0
`define IAD_BF_POSREG      2'd1
`define IAD_BF_PAIR        2'd2
`define IAD_SMAX32         32'h7fffffff
`define IAD_SMIN32         32'h80000000
`define IAD_SMAX8          32'h0000007f
`define IAD_SMIN8          32'hffffff80
`define IAD_UMAX8          32'h000000ff
`define IAD_SMAX16         32'h00007fff
`define IAD_SMIN16         32'hffff8000
`define IAD_UMAX16         32'h0000ffff
`define IAD_LATENCY        1
`endif

//--- hw/iad_datapath.v
// integer datapath: divide steps, magnitude, min/max, clamp, guarded ops, logic, counts, shifts, fields
// Function
// - prep widens dividend, shifts 0/16/24, sign-fills
// - each step yields eight quotient bits
// - quotient low word, remainder high word
// - fixup corrects negative quotient and remainder
// - magnitude and difference magnitude, saturating variants
// - signed and unsigned minimum and maximum
// - clamp word into byte or half range
// - condition register nonzero means true
// - guarded add/sub on true, inverse on false
// - select first source if true, else second
// - and/or/xor, inverted outputs, inverted-input and/or
// - sign count is leading sign bits minus one
// - zero count 32, one count 32, sign 31
// - zero count from msb, zero when msb set
// - signed amount: left n[4:0], right (-n)[4:0]
// - zero fill both ways; arithmetic right fills sign
// - clamped shift saturates on lost sign bits
// - unsigned field pull zeroes upper bits
// - signed field pull extends field msb
// - width/pos from immediates, imm+register, register pair
// - pair window pull is upper word of shifted concatenation
// - insert low w bits at pos, or 4-bit constant
`include "iad_defines.vh"
module iad_datapath (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // instruction issue
  input  wire        issue,
  input  wire [5:0]  op,
  input  wire [3:0]  src_a,
  input  wire [3:0]  src_b,
  input  wire [3:0]  src_cond,
  input  wire [3:0]  src_field,
  input  wire [3:0]  dst,
  input  wire        use_imm,
  input  wire [15:0] imm,
  input  wire [1:0]  field_mode,
  input  wire [4:0]  imm_pos,
  input  wire [5:0]  imm_width,
  // register file load and read port
  input  wire        load_en,
  input  wire [3:0]  load_idx,
  input  wire [31:0] load_data,
  input  wire [3:0]  read_idx,
  output reg  [31:0] read_data_r,
  // writeback report
  output reg         done_r,
  output reg  [3:0]  done_dst_r,
  output reg         done_pair_r,
  output reg  [31:0] result_lo_r,
  output reg  [31:0] result_hi_r
);

  reg  [31:0] gpr [0:15];
  reg         qneg_r;
  reg         rneg_r;
  reg         qneg_nxt;
  reg         rneg_nxt;
  reg  [31:0] res_lo_nxt;
  reg  [31:0] res_hi_nxt;
  reg         pair_nxt;
  reg  [63:0] wide;
  reg  [32:0] rem;
  reg  [31:0] quo;
  reg  [31:0] dmag;
  reg  [32:0] dif;
  reg  [5:0]  qsh;
  reg  [5:0]  fw;
  reg  [4:0]  fp;
  reg  [31:0] fmask;
  reg  [31:0] fval;
  reg         qbit;
  reg         sgn_div;
  reg         uns_div;
  integer     i;

  wire [31:0] opa     = gpr[src_a];
  wire [31:0] opa_hi  = gpr[{src_a[3:1], 1'b1}];
  wire [31:0] opb     = use_imm ? {{16{imm[15]}}, imm} : gpr[src_b];
  wire [31:0] fld_lo  = gpr[src_field];
  wire [31:0] fld_hi  = gpr[{src_field[3:1], 1'b1}];
  wire        cond    = gpr[src_cond] != 32'h0;
  wire [31:0] neg_b   = 32'h0 - opb;
  wire        shr     = opb[31];
  wire [4:0]  shamt   = shr ? neg_b[4:0] : opb[4:0];
  wire [3:0]  pair_lo = {dst[3:1], 1'b0};

  // count of leading bits equal to b
  function [5:0] lead_cnt;
    input [31:0] x;
    input        b;
    integer      k;
    reg          stop;
    begin
      lead_cnt = 6'd0;
      stop = 1'b0;
      for (k = 31; k >= 0; k = k - 1) begin
        if (!stop && x[k] == b) begin
          lead_cnt = lead_cnt + 6'd1;
        end else begin
          stop = 1'b1;
        end
      end
    end
  endfunction

  // two's complement magnitude
  function [31:0] mag;
    input [31:0] x;
    begin
      mag = x[31] ? (32'h0 - x) : x;
    end
  endfunction

  // signed clamp of a word into [lo, hi]
  function [31:0] sclamp;
    input [31:0] x;
    input [31:0] hi;
    input [31:0] lo;
    begin
      if ($signed(x) > $signed(hi)) begin
        sclamp = hi;
      end else if ($signed(x) < $signed(lo)) begin
        sclamp = lo;
      end else begin
        sclamp = x;
      end
    end
  endfunction

  // odd register of the pair holding idx
  function [3:0] pair_odd;
    input [3:0] idx;
    begin
      pair_odd = {idx[3:1], 1'b1};
    end
  endfunction

  // unsigned clamp of a word to hi
  function [31:0] uclamp;
    input [31:0] x;
    input [31:0] hi;
    begin
      uclamp = (x > hi) ? hi : x;
    end
  endfunction

  // arithmetic right shift kept signed inside its own context
  function [31:0] sra;
    input [31:0] x;
    input [4:0]  n;
    begin
      sra = $signed(x) >>> n;
    end
  endfunction

  // writeback indices of the issued instruction
  wire [3:0]  pair_hi = pair_odd(dst);
  wire [3:0]  wb_idx  = pair_nxt ? pair_lo : dst;
  // a load colliding with the issued writeback is dropped
  wire        ld_hit  = issue && (load_idx == wb_idx || (pair_nxt && load_idx == pair_hi));

  // width and position selection
  always @* begin
    fw = imm_width;
    fp = imm_pos;
    case (field_mode)
      `IAD_BF_POSREG: begin
        fp = fld_lo[4:0];
      end
      `IAD_BF_PAIR: begin
        fp = fld_lo[4:0];
        fw = (fld_hi[5:0] > 6'd32) ? 6'd32 : fld_hi[5:0];
      end
      default: begin
        fw = imm_width;
      end
    endcase
    if (fw > 6'd32) begin
      fw = 6'd32;
    end
    fmask = (fw == 6'd32) ? 32'hffffffff : ((32'h1 << fw) - 32'h1);
  end

  // result computation
  always @* begin
    res_lo_nxt = opa;
    res_hi_nxt = 32'h0;
    pair_nxt   = 1'b0;
    qneg_nxt   = qneg_r;
    rneg_nxt   = rneg_r;
    wide       = 64'h0;
    rem        = 33'h0;
    quo        = 32'h0;
    dmag       = 32'h0;
    dif        = 33'h0;
    qsh        = `IAD_QSH_W;
    fval       = 32'h0;
    qbit       = 1'b0;
    sgn_div    = 1'b0;
    uns_div    = 1'b0;
    i          = 0;
    case (op)
      `IAD_OP_QPREP_W, `IAD_OP_QPREP_WU, `IAD_OP_QPREP_H, `IAD_OP_QPREP_HU,
      `IAD_OP_QPREP_B, `IAD_OP_QPREP_BU: begin
        uns_div = op[0];
        qsh = (op[2:1] == 2'd0) ? `IAD_QSH_W : ((op[2:1] == 2'd1) ? `IAD_QSH_H : `IAD_QSH_B);
        qneg_nxt = !uns_div && (opa[31] ^ opb[31]);
        rneg_nxt = !uns_div && opa[31];
        // magnitude widened, shifted, low bits filled with quotient sign
        wide = ({32'h0, uns_div ? opa : mag(opa)} << qsh) |
               (qneg_nxt ? ((64'h1 << qsh) - 64'h1) : 64'h0);
        res_lo_nxt = wide[31:0];
        res_hi_nxt = wide[63:32];
        pair_nxt = 1'b1;
      end
      `IAD_OP_QSTEP, `IAD_OP_QSTEP_U: begin
        sgn_div = (op == `IAD_OP_QSTEP);
        dmag = sgn_div ? mag(opb) : opb;
        rem = {1'b0, opa_hi};
        quo = opa;
        for (i = 0; i < `IAD_STEP_BITS; i = i + 1) begin
          rem = {rem[31:0], quo[31]};
          quo = {quo[30:0], 1'b0};
          qbit = rem >= {1'b0, dmag};
          if (qbit) begin
            rem = rem - {1'b0, dmag};
          end
          quo[0] = qbit ^ (sgn_div & qneg_r);
        end
        res_lo_nxt = quo;
        res_hi_nxt = rem[31:0];
        pair_nxt = 1'b1;
      end
      `IAD_OP_FIXUP: begin
        res_lo_nxt = qneg_r ? (opa + 32'h1) : opa;
        res_hi_nxt = rneg_r ? (32'h0 - opa_hi) : opa_hi;
        pair_nxt = 1'b1;
      end
      `IAD_OP_MAG: res_lo_nxt = mag(opa);
      `IAD_OP_MAG_S: res_lo_nxt = (opa == `IAD_SMIN32) ? `IAD_SMAX32 : mag(opa);
      `IAD_OP_DMAG, `IAD_OP_DMAG_S: begin
        dif = {opa[31], opa} - {opb[31], opb};
        dif = dif[32] ? (33'h0 - dif) : dif;
        res_lo_nxt = dif[31:0];
        if (op == `IAD_OP_DMAG_S && dif[32:31] != 2'b00) begin
          res_lo_nxt = `IAD_SMAX32;
        end
      end
      `IAD_OP_MIN: res_lo_nxt = ($signed(opa) < $signed(opb)) ? opa : opb;
      `IAD_OP_MIN_U: res_lo_nxt = (opa < opb) ? opa : opb;
      `IAD_OP_MAX: res_lo_nxt = ($signed(opa) > $signed(opb)) ? opa : opb;
      `IAD_OP_MAX_U: res_lo_nxt = (opa > opb) ? opa : opb;
      `IAD_OP_CLAMP_B: res_lo_nxt = sclamp(opa, `IAD_SMAX8, `IAD_SMIN8);
      `IAD_OP_CLAMP_BU: res_lo_nxt = uclamp(opa, `IAD_UMAX8);
      `IAD_OP_CLAMP_H: res_lo_nxt = sclamp(opa, `IAD_SMAX16, `IAD_SMIN16);
      `IAD_OP_CLAMP_HU: res_lo_nxt = uclamp(opa, `IAD_UMAX16);
      `IAD_OP_GADD: res_lo_nxt = cond ? (opa + opb) : opa;
      `IAD_OP_GSUB: res_lo_nxt = cond ? (opa - opb) : opa;
      `IAD_OP_IGADD: res_lo_nxt = !cond ? (opa + opb) : opa;
      `IAD_OP_IGSUB: res_lo_nxt = !cond ? (opa - opb) : opa;
      `IAD_OP_SELECT: res_lo_nxt = cond ? opa : opb;
      `IAD_OP_AND: res_lo_nxt = opa & opb;
      `IAD_OP_OR: res_lo_nxt = opa | opb;
      `IAD_OP_XOR: res_lo_nxt = opa ^ opb;
      `IAD_OP_NAND: res_lo_nxt = ~(opa & opb);
      `IAD_OP_NOR: res_lo_nxt = ~(opa | opb);
      `IAD_OP_XNOR: res_lo_nxt = ~(opa ^ opb);
      `IAD_OP_ANDINV: res_lo_nxt = opa & ~opb;
      `IAD_OP_ORINV: res_lo_nxt = opa | ~opb;
      `IAD_OP_ZLEAD: res_lo_nxt = {26'h0, lead_cnt(opa, 1'b0)};
      `IAD_OP_OLEAD: res_lo_nxt = {26'h0, lead_cnt(opa, 1'b1)};
      `IAD_OP_SLEAD: res_lo_nxt = {26'h0, lead_cnt(opa, opa[31]) - 6'd1};
      `IAD_OP_ZFMOVE: res_lo_nxt = shr ? (opa >> shamt) : (opa << shamt);
      `IAD_OP_SMOVE: res_lo_nxt = shr ? sra(opa, shamt) : (opa << shamt);
      `IAD_OP_CSMOVE: begin
        wide = {{32{opa[31]}}, opa} << shamt;
        res_lo_nxt = shr ? sra(opa, shamt) : wide[31:0];
        // lost bits and the result sign bit must all match the source sign
        if (!shr && wide[63:31] != {33{opa[31]}}) begin
          res_lo_nxt = opa[31] ? `IAD_SMIN32 : `IAD_SMAX32;
        end
      end
      `IAD_OP_PULL_U: res_lo_nxt = (opa >> fp) & fmask;
      `IAD_OP_PULL_S: begin
        fval = (opa >> fp) & fmask;
        res_lo_nxt = (fw != 6'd0 && fval[fw[4:0] - 5'd1]) ? (fval | ~fmask) : fval;
      end
      `IAD_OP_PAIRPULL: begin
        wide = {opa, gpr[src_b]} << fp;
        res_lo_nxt = wide[63:32];
      end
      `IAD_OP_INSERT: begin
        fval = use_imm ? {28'h0, imm[3:0]} : gpr[src_b];
        res_lo_nxt = (opa & ~(fmask << fp)) | ((fval & fmask) << fp);
      end
      default: begin
        res_lo_nxt = opa;
      end
    endcase
  end

  // writeback and divide sign state
  always @(posedge clk) begin
    if (rst) begin
      done_r      <= 1'b0;
      done_dst_r  <= 4'h0;
      done_pair_r <= 1'b0;
      result_lo_r <= 32'h0;
      result_hi_r <= 32'h0;
      qneg_r      <= 1'b0;
      rneg_r      <= 1'b0;
      read_data_r <= 32'h0;
    end else begin
      done_r      <= issue;
      read_data_r <= gpr[read_idx];
      if (issue) begin
        done_dst_r  <= wb_idx;
        done_pair_r <= pair_nxt;
        result_lo_r <= res_lo_nxt;
        result_hi_r <= res_hi_nxt;
        qneg_r      <= qneg_nxt;
        rneg_r      <= rneg_nxt;
      end
    end
  end

  // register file: issued writeback wins over load on same register
  always @(posedge clk) begin
    if (load_en && !ld_hit) begin
      gpr[load_idx] <= load_data;
    end
    if (issue && !rst) begin
      if (pair_nxt) begin
        gpr[pair_lo] <= res_lo_nxt;
        gpr[pair_hi] <= res_hi_nxt;
      end else begin
        gpr[dst] <= res_lo_nxt;
      end
    end
  end

endmodule

//--- testbench/iad_datapath_sva.sv
// port checker for the integer datapath
`include "iad_defines.vh"
module iad_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // issue side
  input wire logic        issue,
  input wire logic [5:0]  op,
  input wire logic [3:0]  src_a,
  input wire logic [3:0]  src_b,
  input wire logic [3:0]  src_cond,
  input wire logic [3:0]  dst,
  input wire logic        use_imm,
  // writeback side
  input wire logic        done_r,
  input wire logic [3:0]  done_dst_r,
  input wire logic        done_pair_r,
  input wire logic [31:0] result_lo_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_lat; issue |=> done_r; endproperty
  a_lat: assert property (p_lat) else $error("late done");
  property p_quiet; !issue |=> !done_r; endproperty
  a_quiet: assert property (p_quiet) else $error("stray done");
  property p_dst; issue |=> done_dst_r[3:1] == $past(dst[3:1]); endproperty
  a_dst: assert property (p_dst) else $error("wrong dst");
  property p_pair; issue |=> done_pair_r == ($past(op) <= `IAD_OP_FIXUP); endproperty
  a_pair: assert property (p_pair) else $error("wrong pair flag");
  property p_hold; !issue |=> $stable(result_lo_r); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_xor; issue && op == `IAD_OP_XOR && src_a == src_b && !use_imm |=> result_lo_r == 32'h0; endproperty
  a_xor: assert property (p_xor) else $error("self xor");
  property p_orinv; issue && op == `IAD_OP_ORINV && src_a == src_b && !use_imm |=> &result_lo_r; endproperty
  a_orinv: assert property (p_orinv) else $error("self orinv");
  property p_gsub;
    issue && op == `IAD_OP_GSUB && src_a == src_b && src_a == src_cond && !use_imm |=> result_lo_r == 32'h0;
  endproperty
  a_gsub: assert property (p_gsub) else $error("self gsub");
endmodule

bind iad_datapath iad_checker u_chk (.clk, .rst, .issue, .op, .src_a, .src_b, .src_cond, .dst, .use_imm,
  .done_r, .done_dst_r, .done_pair_r, .result_lo_r);

//--- testbench/iad_core_model.sv
// core decode side: register preload and instruction issue
module iad_core_model (
  // clock
  input  wire logic   clk,
  // instruction issue
  output logic        issue,
  output logic [5:0]  op,
  output logic [3:0]  src_a,
  output logic [3:0]  src_b,
  output logic [3:0]  src_cond,
  output logic [3:0]  src_field,
  output logic [3:0]  dst,
  output logic        use_imm,
  output logic [15:0] imm,
  output logic [1:0]  field_mode,
  output logic [4:0]  imm_pos,
  output logic [5:0]  imm_width,
  // register preload
  output logic        load_en,
  output logic [3:0]  load_idx,
  output logic [31:0] load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {issue, load_en, use_imm, imm, field_mode, imm_pos, imm_width} = '0;
    {op, src_a, src_b, src_cond, src_field, dst, load_idx, load_data} = '0;
  end
  // one register write per cycle
  task automatic ld(input logic [3:0] i, input logic [31:0] v);
    @(negedge clk);
    issue = 1'b0;
    load_en = 1'b1;
    load_idx = i;
    load_data = v;
  endtask
  // one instruction, held for one issue edge
  task automatic run(input logic [5:0] o, input logic [3:0] a, b, c, d);
    @(negedge clk);
    load_en = 1'b0;
    {op, src_a, src_b, src_cond, src_field, dst} = {o, a, b, c, c, d};
    issue = 1'b1;
    @(negedge clk);
    issue = 1'b0;
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the integer datapath
`include "iad_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, issue, use_imm, load_en, done_r, done_pair_r;
  logic [1:0]  field_mode;
  logic [3:0]  src_a, src_b, src_cond, src_field, dst, load_idx, read_idx, done_dst_r;
  logic [4:0]  imm_pos;
  logic [5:0]  op, imm_width;
  logic [15:0] imm;
  logic [31:0] load_data, read_data_r, result_lo_r, result_hi_r;
  int          failures, checks;
  iad_core_model u_core (.clk, .issue, .op, .src_a, .src_b, .src_cond, .src_field, .dst, .use_imm, .imm,
    .field_mode, .imm_pos, .imm_width, .load_en, .load_idx, .load_data);
  iad_datapath u_dut (.clk, .rst, .issue, .op, .src_a, .src_b, .src_cond, .src_field, .dst, .use_imm, .imm,
    .field_mode, .imm_pos, .imm_width, .load_en, .load_idx, .load_data, .read_idx, .read_data_r, .done_r,
    .done_dst_r, .done_pair_r, .result_lo_r, .result_hi_r);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // preload d1..d3, run into d4, check done, result and stored word
  task automatic x(input logic [5:0] o, input logic [31:0] a, b, c, e);
    u_core.ld(4'h1, a);
    u_core.ld(4'h2, b);
    u_core.ld(4'h3, c);
    u_core.run(o, 4'h1, 4'h2, 4'h3, 4'h4);
    cmp({31'h0, done_r}, 32'h1, "done");
    cmp(result_lo_r, e, "result");
    cmp({28'h0, done_dst_r}, 32'h4, "dst");
    @(negedge clk);
    cmp(read_data_r, e, "stored");
  endtask
  // prep, steps and fixup into d6/d7, then check prep word, pair, quotient and remainder
  task automatic dv(input logic [5:0] p, s, input int n, input logic [31:0] a, b, ep, eq, er);
    u_core.ld(4'h1, a);
    u_core.ld(4'h2, b);
    u_core.run(p, 4'h1, 4'h2, 4'h0, 4'h6);
    cmp(result_lo_r, ep, "prep");
    repeat (n) u_core.run(s, 4'h6, 4'h2, 4'h0, 4'h6);
    cmp({31'h0, done_pair_r}, 32'h1, "pair");
    u_core.run(`IAD_OP_FIXUP, 4'h6, 4'h2, 4'h0, 4'h6);
    cmp({28'h0, done_dst_r}, 32'h6, "pair dst");
    cmp(result_lo_r, eq, "quotient");
    cmp(result_hi_r, er, "remainder");
  endtask
  task automatic t_div;
    u_core.ld(4'h1, 32'd200);
    u_core.ld(4'h2, 32'd7);
    u_core.run(`IAD_OP_QPREP_BU, 4'h1, 4'h2, 4'h0, 4'h6);
    cmp(result_lo_r, 32'hc8000000, "prep");
    u_core.run(`IAD_OP_QSTEP_U, 4'h6, 4'h2, 4'h0, 4'h6);
    cmp(result_lo_r, 32'd28, "quotient");
    cmp(result_hi_r, 32'd4, "remainder");
    u_core.ld(4'h1, 32'hffffff9c);
    u_core.run(`IAD_OP_QPREP_W, 4'h1, 4'h2, 4'h0, 4'h6);
    repeat (4) u_core.run(`IAD_OP_QSTEP, 4'h6, 4'h2, 4'h0, 4'h6);
    u_core.run(`IAD_OP_FIXUP, 4'h6, 4'h2, 4'h0, 4'h6);
    cmp(result_lo_r, 32'hfffffff2, "signed quotient");
    cmp(result_hi_r, 32'hfffffffe, "signed remainder");
    dv(`IAD_OP_QPREP_HU, `IAD_OP_QSTEP_U, 2, 32'd1000, 32'd3, 32'h03e80000, 32'h14d, 32'h1);
    dv(`IAD_OP_QPREP_H, `IAD_OP_QSTEP, 2, 32'd1000, 32'hfffffffd, 32'h03e8ffff, 32'hfffffeb3, 32'h1);
    dv(`IAD_OP_QPREP_B, `IAD_OP_QSTEP, 1, 32'hffffff9c, 32'd7, 32'h64ffffff, 32'hfffffff2, 32'hfffffffe);
    dv(`IAD_OP_QPREP_WU, `IAD_OP_QSTEP_U, 4, 32'hffffffff, 32'h10, 32'hffffffff, 32'h0fffffff, 32'hf);
    $display("divide test ended");
  endtask
  task automatic t_arith;
    x(`IAD_OP_MAG, 32'h80000000, 0, 0, 32'h80000000);
    x(`IAD_OP_MAG_S, 32'h80000000, 0, 0, 32'h7fffffff);
    x(`IAD_OP_DMAG, 32'h5, 32'hfffffffd, 0, 32'h8);
    x(`IAD_OP_DMAG_S, 32'h7fffffff, 32'h80000000, 0, 32'h7fffffff);
    x(`IAD_OP_MIN, 32'hffffffff, 32'h1, 0, 32'hffffffff);
    x(`IAD_OP_MIN_U, 32'hffffffff, 32'h1, 0, 32'h1);
    x(`IAD_OP_MAX, 32'hffffffff, 32'h1, 0, 32'h1);
    x(`IAD_OP_MAX_U, 32'hffffffff, 32'h1, 0, 32'hffffffff);
    x(`IAD_OP_CLAMP_B, 32'h12345, 0, 0, 32'h7f);
    x(`IAD_OP_CLAMP_B, 32'hffffff38, 0, 0, 32'hffffff80);
    x(`IAD_OP_CLAMP_BU, 32'h12345, 0, 0, 32'hff);
    x(`IAD_OP_CLAMP_H, 32'h12345, 0, 0, 32'h7fff);
    x(`IAD_OP_CLAMP_HU, 32'h12345, 0, 0, 32'hffff);
    $display("arith test ended");
  endtask
  task automatic t_guard;
    logic [31:0] c;
    for (int i = 0; i < 2; i++) begin
      c = i ? 32'h100 : 32'h0;
      x(`IAD_OP_GADD, 32'd5, 32'd3, c, i ? 32'd8 : 32'd5);
      x(`IAD_OP_GSUB, 32'd5, 32'd3, c, i ? 32'd2 : 32'd5);
      x(`IAD_OP_IGADD, 32'd5, 32'd3, c, i ? 32'd5 : 32'd8);
      x(`IAD_OP_IGSUB, 32'd5, 32'd3, c, i ? 32'd5 : 32'd2);
      x(`IAD_OP_SELECT, 32'd5, 32'd3, c, i ? 32'd5 : 32'd3);
    end
    $display("guard test ended");
  endtask
  task automatic t_logic;
    logic [5:0]  lo[8] = '{`IAD_OP_AND, `IAD_OP_OR, `IAD_OP_XOR, `IAD_OP_NAND, `IAD_OP_NOR, `IAD_OP_XNOR,
                          `IAD_OP_ANDINV, `IAD_OP_ORINV};
    logic [31:0] le[8] = '{32'h88, 32'hee, 32'h66, 32'hffffff77, 32'hffffff11, 32'hffffff99, 32'h44, 32'hffffffdd};
    for (int i = 0; i < 8; i++) x(lo[i], 32'hcc, 32'haa, 0, le[i]);
    u_core.run(`IAD_OP_XOR, 4'h1, 4'h1, 4'h1, 4'h4);
    u_core.run(`IAD_OP_ORINV, 4'h1, 4'h1, 4'h1, 4'h4);
    u_core.run(`IAD_OP_GSUB, 4'h1, 4'h1, 4'h1, 4'h4);
    cmp(result_lo_r, 32'h0, "self subtract");
    $display("logic test ended");
  endtask
  task automatic t_count;
    x(`IAD_OP_ZLEAD, 32'h0, 0, 0, 32'd32);
    x(`IAD_OP_ZLEAD, 32'h01000000, 0, 0, 32'd7);
    x(`IAD_OP_ZLEAD, 32'h80000000, 0, 0, 32'd0);
    x(`IAD_OP_OLEAD, 32'hffffffff, 0, 0, 32'd32);
    x(`IAD_OP_OLEAD, 32'hf0000000, 0, 0, 32'd4);
    x(`IAD_OP_SLEAD, 32'h0, 0, 0, 32'd31);
    x(`IAD_OP_SLEAD, 32'hffffffff, 0, 0, 32'd31);
    x(`IAD_OP_SLEAD, 32'h00ff0000, 0, 0, 32'd7);
    $display("count test ended");
  endtask
  task automatic t_shift;
    x(`IAD_OP_ZFMOVE, 32'h2, 32'hffffffff, 0, 32'h1);
    u_core.use_imm = 1'b1;
    u_core.imm = 16'hfffc;
    x(`IAD_OP_ZFMOVE, 32'h80000010, 0, 0, 32'h08000001);
    x(`IAD_OP_SMOVE, 32'h80000010, 0, 0, 32'hf8000001);
    x(`IAD_OP_CSMOVE, 32'h80000010, 0, 0, 32'hf8000001);
    u_core.imm = 16'h0004;
    x(`IAD_OP_ZFMOVE, 32'h11, 0, 0, 32'h110);
    x(`IAD_OP_SMOVE, 32'hffffffff, 0, 0, 32'hfffffff0);
    x(`IAD_OP_CSMOVE, 32'h10000000, 0, 0, 32'h7fffffff);
    x(`IAD_OP_CSMOVE, 32'h90000001, 0, 0, 32'h80000000);
    x(`IAD_OP_CSMOVE, 32'hf8000001, 0, 0, 32'h80000010);
    u_core.use_imm = 1'b0;
    $display("shift test ended");
  endtask
  task automatic t_field;
    u_core.imm_pos = 5'd4;
    u_core.imm_width = 6'd8;
    x(`IAD_OP_PULL_U, 32'hff0, 0, 0, 32'hff);
    x(`IAD_OP_PULL_S, 32'hff0, 0, 0, 32'hffffffff);
    x(`IAD_OP_PULL_S, 32'h700, 0, 0, 32'h70);
    u_core.imm_width = 6'd4;
    x(`IAD_OP_INSERT, 32'hffffffff, 32'h0, 0, 32'hffffff0f);
    u_core.use_imm = 1'b1;
    u_core.imm = 16'h0005;
    x(`IAD_OP_INSERT, 32'hffffffff, 32'h0, 0, 32'hffffff5f);
    u_core.use_imm = 1'b0;
    u_core.imm_pos = 5'd8;
    x(`IAD_OP_PAIRPULL, 32'h12345678, 32'h9abcdef0, 0, 32'h3456789a);
    x(`IAD_OP_PAIRPULL, 32'h12345678, 32'h12345678, 0, 32'h34567812);
    u_core.imm_width = 6'd8;
    u_core.field_mode = `IAD_BF_POSREG;
    x(`IAD_OP_PULL_U, 32'hab00, 0, 32'h8, 32'hab);
    u_core.field_mode = `IAD_BF_PAIR;
    x(`IAD_OP_PULL_S, 32'hab00, 0, 32'h8, 32'hffffffab);
    u_core.ld(4'h1, 32'hab00);
    u_core.ld(4'h2, 32'h8);
    u_core.ld(4'h3, 32'h4);
    u_core.run(`IAD_OP_PULL_S, 4'h1, 4'h1, 4'h2, 4'h4);
    cmp(result_lo_r, 32'hfffffffb, "pair width");
    u_core.field_mode = `IAD_BF_IMM;
    $display("field test ended");
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    failures = 0;
    checks = 0;
    rst = 1'b1;
    read_idx = 4'h4;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_div();
    t_arith();
    t_guard();
    t_logic();
    t_count();
    t_shift();
    t_field();
    wrap_up();
  end
endmodule
